// *** rtl/exc_pkg.sv ***
// What this block does
// - bus error latches first offending cycle address
// - load/store fault loads instruction info into cause
// - breakpoint register gets first breakpoint cycle address
// - fault registers updated according to exception type
// - return sequence drains, restores context, then refetches
// - exception taken only at completed queue head
// - pipeline kill and state restore within three clocks
// - save context, mask interrupts, privileged, one clock
// - handler fetch starts in restore, issue two to four clocks later
// - pointer and state saved before handler issues
// - reset request always forces the reset exception
// - reset vector chosen by sampled configuration bit
// - reset sets base select, keeps machine check
// - reset clears debug and cache controls, sets mask
// - registers not named stay unchanged through reset, except float cause cleared and counter low halves cleared
// - byte order bit takes handler byte order value
// - entry clears enables, trace, user, float, recoverable
// - state bits 0 to 15 copied into save state
// - handler address is base plus vector offset
package exc_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses on the bus)
   // ---------------------------------------------------------------
   localparam logic [6:0] OFF_MST = 7'h00;
   localparam logic [6:0] OFF_SVPC = 7'h04;
   localparam logic [6:0] OFF_SVST = 7'h08;
   localparam logic [6:0] OFF_FAD = 7'h0C;
   localparam logic [6:0] OFF_FCAUS = 7'h10;
   localparam logic [6:0] OFF_BAR = 7'h14;
   localparam logic [6:0] OFF_FEXC = 7'h18;
   localparam logic [6:0] OFF_IBCTL = 7'h1C;
   localparam logic [6:0] OFF_LCA = 7'h20;
   localparam logic [6:0] OFF_LCB = 7'h24;
   localparam logic [6:0] OFF_CNTA = 7'h28;
   localparam logic [6:0] OFF_CNTB = 7'h2C;
   localparam logic [6:0] OFF_DMC = 7'h30;
   localparam logic [6:0] OFF_DMM = 7'h34;
   localparam logic [6:0] OFF_ICCS = 7'h38;
   localparam logic [6:0] OFF_ICAD = 7'h3C;
   localparam logic [6:0] OFF_ICDT = 7'h40;
   localparam logic [6:0] OFF_STATUS = 7'h44;
   // ---------------------------------------------------------------
   // state register bit positions (bit 0 is the lsb here)
   // ---------------------------------------------------------------
   localparam int MST_HBO = 16;
   localparam int MST_EI = 15;
   localparam int MST_UM = 14;
   localparam int MST_FA = 13;
   localparam int MST_MC = 12;
   localparam int MST_FXA = 11;
   localparam int MST_SS = 10;
   localparam int MST_BT = 9;
   localparam int MST_FXB = 8;
   localparam int MST_VB = 6;
   localparam int MST_RC = 1;
   localparam int MST_BO = 0;
   // ---------------------------------------------------------------
   // reset values and vectors
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_CLEAR = 32'h0000_0000;
   localparam logic [31:0] DMM_SET = 32'h2800_000F;
   localparam logic [31:0] CNT_HI_KEEP = 32'hFFFF_0000;
   localparam logic [31:0] BASE_LOW = 32'h0000_0000;
   localparam logic [31:0] BASE_HIGH = 32'hFFF0_0000;
   localparam logic [31:0] VEC_RESET = 32'h0000_0100;
   // ---------------------------------------------------------------
   // timing counts in core clocks
   // ---------------------------------------------------------------
   localparam int RESTORE_MAX = 3;
   localparam int SAVE_MIN = 1;
   localparam int FETCH_ISSUE_MIN = 2;
   // ---------------------------------------------------------------
   // exception classes and sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      EXC_ALIGN = 2'b00,
      EXC_MCHK = 2'b01,
      EXC_BKPT = 2'b10,
      EXC_OTHER = 2'b11
   } exc_t;
   typedef enum logic [2:0] {
      S_RUN = 3'b000,
      S_RESTORE = 3'b001,
      S_SAVE = 3'b010,
      S_WAIT = 3'b011,
      S_RFI = 3'b100,
      S_RSTHOLD = 3'b101
   } seq_t;
endpackage

// *** rtl/exc_sequencer.sv ***
`timescale 1ns/1ps
module exc_sequencer
#(
   parameter int RESTORE_CYCLES = exc_pkg::RESTORE_MAX
)
(
   // clock and housekeeping reset
   input wire logic clk_i,
   input wire logic rst_i,
   // reset request and configuration from system interface
   input wire logic core_reset_req_i,
   input wire logic cfg_vector_high_i,
   // history queue head
   input wire logic head_valid_i,
   input wire logic head_complete_i,
   input wire logic head_exc_i,
   input wire exc_pkg::exc_t head_exc_type_i,
   input wire logic head_is_rfi_i,
   input wire logic [31:0] head_pc_i,
   input wire logic [31:0] head_vec_off_i,
   input wire logic [15:0] head_exc_info_i,
   input wire logic [31:0] head_data_ea_i,
   input wire logic [31:0] head_instr_info_i,
   // load/store unit cycle events
   input wire logic bus_err_i,
   input wire logic [31:0] bus_err_ea_i,
   input wire logic bkpt_hit_i,
   input wire logic [31:0] bkpt_ea_i,
   // handler issue feedback
   input wire logic handler_issued_i,
   // pipeline control
   output logic retire_o,
   output logic kill_o,
   output logic fetch_req_o,
   output logic [31:0] fetch_addr_o,
   output logic issue_en_o,
   output logic [31:0] machine_state_o,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [6:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import exc_pkg::*;

   if (RESTORE_CYCLES < 1 || RESTORE_CYCLES > RESTORE_MAX)
   begin
      $error("restore cycles out of range");
   end

   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      seq_t state;        // sequencer state
      logic [1:0] rcnt;   // restore cycle counter
      logic [31:0] mst;   // machine_state_reg
      logic [31:0] svpc;  // save_pc_reg
      logic [31:0] svst;  // save_state_reg
      logic [31:0] fad;   // data_fault_address_reg
      logic [31:0] fcaus; // fault_cause_reg
      logic [31:0] bar;   // breakpoint address
      logic [31:0] fexc;  // float_exc_cause_reg
      logic [31:0] ibctl; // instr_bkpt_control
      logic [31:0] lca;   // load_store_bkpt_control_a
      logic [31:0] lcb;   // load_store_bkpt_control_b
      logic [31:0] cnta;  // bkpt_counter_a
      logic [31:0] cntb;  // bkpt_counter_b
      logic [31:0] dmc;   // debug_map_control
      logic [31:0] dmm;   // debug_map_mask
      logic [31:0] iccs;  // icache_control_status
      logic [31:0] icad;  // icache_addr_port
      logic [31:0] icdt;  // icache_data_port
      logic err_seen;     // first bus error of head already caught
      logic [31:0] err_ea;
      logic bk_seen;      // first breakpoint cycle already caught
      logic [31:0] bk_ea;
      logic cfg_vb;       // configuration bit caught during reset
      logic rq_s1;        // reset request synchroniser
      logic rq_s2;
      logic cf_s1;        // configuration synchroniser
      logic cf_s2;
      logic ack;
      logic [31:0] dat;
      logic kill;
      logic fetch;
      logic [31:0] faddr;
      logic issue_en;
      logic retire;
   } st_t;

   st_t st_r;
   st_t st_nxt;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // handler address from base select and offset
   function automatic logic [31:0] vec_addr(input logic vb, input logic [31:0] off);
      vec_addr = (vb ? BASE_HIGH : BASE_LOW) + off;
   endfunction

   // merge a write under byte enables
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] sel);
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      merge = (old & ~m) | (d & m);
   endfunction

   // entry value of the state register for non-reset exceptions
   function automatic logic [31:0] entry_mst(input logic [31:0] m);
      logic [31:0] r;
      r = m;
      r[MST_EI] = 1'b0;
      r[MST_UM] = 1'b0;
      r[MST_FA] = 1'b0;
      r[MST_FXA] = 1'b0;
      r[MST_FXB] = 1'b0;
      r[MST_SS] = 1'b0;
      r[MST_BT] = 1'b0;
      r[MST_RC] = 1'b0;
      r[MST_BO] = m[MST_HBO];
      entry_mst = r;
   endfunction

   logic wb_req;
   logic head_ok;
   logic [31:0] first_err_ea;
   logic [31:0] first_bk_ea;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;
      // head may leave only when complete, earlier ones are gone by queue order
      head_ok = head_valid_i && head_complete_i;
      // an error in this very cycle counts if none caught yet
      first_err_ea = st_r.err_seen ? st_r.err_ea : bus_err_ea_i;
      first_bk_ea = st_r.bk_seen ? st_r.bk_ea : bkpt_ea_i;

      // pulses default low
      st_nxt.kill = 1'b0;
      st_nxt.fetch = 1'b0;
      st_nxt.retire = 1'b0;
      st_nxt.ack = 1'b0;

      // synchronisers: the reset request is asynchronous to the core
      st_nxt.rq_s1 = core_reset_req_i;
      st_nxt.rq_s2 = st_r.rq_s1;
      st_nxt.cf_s1 = cfg_vector_high_i;
      st_nxt.cf_s2 = st_r.cf_s1;

      // catch the first offending cycle of the instruction in flight
      if (bus_err_i && !st_r.err_seen)
      begin
         st_nxt.err_seen = 1'b1;
         st_nxt.err_ea = bus_err_ea_i;
      end
      if (bkpt_hit_i && !st_r.bk_seen)
      begin
         st_nxt.bk_seen = 1'b1;
         st_nxt.bk_ea = bkpt_ea_i;
      end

      // wishbone slave: one wait state, unmapped reads zero
      if (wb_req)
      begin
         st_nxt.ack = 1'b1;
         st_nxt.dat = 32'h0000_0000;
         case (wb_adr_i)
            OFF_MST: st_nxt.dat = st_r.mst;
            OFF_SVPC: st_nxt.dat = st_r.svpc;
            OFF_SVST: st_nxt.dat = st_r.svst;
            OFF_FAD: st_nxt.dat = st_r.fad;
            OFF_FCAUS: st_nxt.dat = st_r.fcaus;
            OFF_BAR: st_nxt.dat = st_r.bar;
            OFF_FEXC: st_nxt.dat = st_r.fexc;
            OFF_IBCTL: st_nxt.dat = st_r.ibctl;
            OFF_LCA: st_nxt.dat = st_r.lca;
            OFF_LCB: st_nxt.dat = st_r.lcb;
            OFF_CNTA: st_nxt.dat = st_r.cnta;
            OFF_CNTB: st_nxt.dat = st_r.cntb;
            OFF_DMC: st_nxt.dat = st_r.dmc;
            OFF_DMM: st_nxt.dat = st_r.dmm;
            OFF_ICCS: st_nxt.dat = st_r.iccs;
            OFF_ICAD: st_nxt.dat = st_r.icad;
            OFF_ICDT: st_nxt.dat = st_r.icdt;
            OFF_STATUS: st_nxt.dat = {28'h000_0000, st_r.cfg_vb, st_r.state};
            default: st_nxt.dat = 32'h0000_0000;
         endcase
         if (wb_we_i)
         begin
            // writes land first so that hardware updates below win
            case (wb_adr_i)
               OFF_MST: st_nxt.mst = merge(st_r.mst, wb_dat_i, wb_sel_i);
               OFF_SVPC: st_nxt.svpc = merge(st_r.svpc, wb_dat_i, wb_sel_i);
               OFF_SVST: st_nxt.svst = merge(st_r.svst, wb_dat_i, wb_sel_i);
               OFF_FAD: st_nxt.fad = merge(st_r.fad, wb_dat_i, wb_sel_i);
               OFF_FCAUS: st_nxt.fcaus = merge(st_r.fcaus, wb_dat_i, wb_sel_i);
               OFF_BAR: st_nxt.bar = merge(st_r.bar, wb_dat_i, wb_sel_i);
               OFF_FEXC: st_nxt.fexc = merge(st_r.fexc, wb_dat_i, wb_sel_i);
               OFF_IBCTL: st_nxt.ibctl = merge(st_r.ibctl, wb_dat_i, wb_sel_i);
               OFF_LCA: st_nxt.lca = merge(st_r.lca, wb_dat_i, wb_sel_i);
               OFF_LCB: st_nxt.lcb = merge(st_r.lcb, wb_dat_i, wb_sel_i);
               OFF_CNTA: st_nxt.cnta = merge(st_r.cnta, wb_dat_i, wb_sel_i);
               OFF_CNTB: st_nxt.cntb = merge(st_r.cntb, wb_dat_i, wb_sel_i);
               OFF_DMC: st_nxt.dmc = merge(st_r.dmc, wb_dat_i, wb_sel_i);
               OFF_DMM: st_nxt.dmm = merge(st_r.dmm, wb_dat_i, wb_sel_i);
               OFF_ICCS: st_nxt.iccs = merge(st_r.iccs, wb_dat_i, wb_sel_i);
               OFF_ICAD: st_nxt.icad = merge(st_r.icad, wb_dat_i, wb_sel_i);
               OFF_ICDT: st_nxt.icdt = merge(st_r.icdt, wb_dat_i, wb_sel_i);
               default: st_nxt.dat = st_nxt.dat; // unmapped or read-only
            endcase
         end
      end

      // sequencer
      case (st_r.state)
         // normal running: retire, take an exception or a return
         S_RUN:
         begin
            if (head_ok && head_exc_i)
            begin
               // exception recognised at the head
               st_nxt.kill = 1'b1;
               st_nxt.fetch = 1'b1;
               st_nxt.faddr = vec_addr(st_r.mst[MST_VB], head_vec_off_i);
               st_nxt.rcnt = 2'(RESTORE_CYCLES - 1);
               st_nxt.state = S_RESTORE;
               st_nxt.svpc = head_pc_i;
               st_nxt.svst = {head_exc_info_i, st_r.mst[15:0]};
               st_nxt.mst = entry_mst(st_r.mst);
               case (head_exc_type_i)
                  EXC_ALIGN:
                  begin
                     st_nxt.fad = head_data_ea_i;
                     st_nxt.fcaus = head_instr_info_i;
                  end
                  EXC_MCHK:
                  begin
                     st_nxt.fad = first_err_ea;
                     st_nxt.fcaus = head_instr_info_i;
                  end
                  EXC_BKPT: st_nxt.bar = first_bk_ea;
                  default: st_nxt.fad = st_nxt.fad;
               endcase
               st_nxt.err_seen = 1'b0;
               st_nxt.bk_seen = 1'b0;
            end
            else if (head_ok && head_is_rfi_i)
            begin
               // all older ones are retired; drop younger, reload context
               st_nxt.kill = 1'b1;
               st_nxt.retire = 1'b1;
               st_nxt.mst = {st_r.mst[31:16], st_r.svst[15:0]};
               st_nxt.fetch = 1'b1;
               st_nxt.faddr = st_r.svpc;
               st_nxt.state = S_RFI;
               st_nxt.err_seen = 1'b0;
               st_nxt.bk_seen = 1'b0;
            end
            else if (head_ok)
            begin
               st_nxt.retire = 1'b1;
               st_nxt.err_seen = 1'b0;
               st_nxt.bk_seen = 1'b0;
            end
         end
         // machine state being restored; fetch already going
         S_RESTORE:
         begin
            if (st_r.rcnt == 2'd0)
               st_nxt.state = S_SAVE;
            else
               st_nxt.rcnt = st_r.rcnt - 2'd1;
         end
         // context save: one clock before the handler may issue
         S_SAVE:
         begin
            st_nxt.issue_en = 1'b1;
            st_nxt.state = S_WAIT;
         end
         // handler issue enabled until the first one goes
         S_WAIT:
         begin
            if (handler_issued_i)
            begin
               st_nxt.issue_en = 1'b0;
               st_nxt.state = S_RUN;
            end
         end
         // return: new context takes effect for the refetched stream
         S_RFI:
         begin
            st_nxt.state = S_RUN;
         end
         // reset held: nothing runs, configuration sampled
         S_RSTHOLD:
         begin
            st_nxt.cfg_vb = st_r.cf_s2;
            if (!st_r.rq_s2)
            begin
               st_nxt.mst = RST_CLEAR;
               st_nxt.mst[MST_MC] = st_r.mst[MST_MC];
               st_nxt.mst[MST_VB] = st_r.cfg_vb;
               st_nxt.fexc = RST_CLEAR;
               st_nxt.ibctl = RST_CLEAR;
               st_nxt.lca = RST_CLEAR;
               st_nxt.lcb = RST_CLEAR;
               st_nxt.cnta = st_r.cnta & CNT_HI_KEEP;
               st_nxt.cntb = st_r.cntb & CNT_HI_KEEP;
               st_nxt.dmc = RST_CLEAR;
               st_nxt.dmm = st_r.dmm | DMM_SET;
               st_nxt.iccs = RST_CLEAR;
               // save registers, cache ports, fault registers untouched
               st_nxt.fetch = 1'b1;
               st_nxt.faddr = vec_addr(st_r.cfg_vb, VEC_RESET);
               st_nxt.issue_en = 1'b1;
               st_nxt.state = S_WAIT;
            end
         end
         default: st_nxt.state = S_RUN;
      endcase

      // reset request beats anything else in flight
      if (st_r.rq_s2 && st_r.state != S_RSTHOLD)
      begin
         st_nxt.state = S_RSTHOLD;
         st_nxt.kill = 1'b1;
         st_nxt.fetch = 1'b0;
         st_nxt.retire = 1'b0;
         st_nxt.issue_en = 1'b0;
         st_nxt.err_seen = 1'b0;
         st_nxt.bk_seen = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // housekeeping reset clears everything; the architectural reset
   // exception is the request input and runs through the sequencer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ---------------------------------------------------------------
   // outputs straight from the record
   // ---------------------------------------------------------------
   assign retire_o = st_r.retire;
   assign kill_o = st_r.kill;
   assign fetch_req_o = st_r.fetch;
   assign fetch_addr_o = st_r.faddr;
   assign issue_en_o = st_r.issue_en;
   assign machine_state_o = st_r.mst;
   assign wb_dat_o = st_r.dat;
   assign wb_ack_o = st_r.ack;
endmodule

// *** dv/exc_props.sv ***
`timescale 1ns/1ps
module exc_props
   import exc_pkg::*;
#(
   parameter int RESTORE_CYCLES = 3
)
(
   // clock and resets
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic core_reset_req_i,
   // handler handshake
   input wire logic handler_issued_i,
   // pipeline control
   input wire logic retire_o,
   input wire logic kill_o,
   input wire logic fetch_req_o,
   input wire logic [31:0] fetch_addr_o,
   input wire logic issue_en_o,
   input wire logic [31:0] machine_state_o
);
   // ------------------------------------------------------------
   // helper terms
   // ------------------------------------------------------------
   // exception entry: kill and vector fetch, nothing retired
   wire logic exc_entry = kill_o && fetch_req_o && !retire_o;
   // reset handler fetch is the only fetch without a kill
   wire logic rst_fetch = fetch_req_o && !kill_o;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_vector_base: assert property (fetch_req_o && !retire_o |->
      (fetch_addr_o & BASE_HIGH) == (machine_state_o[MST_VB] ? BASE_HIGH : BASE_LOW))
      else $error("vector base does not follow base select");
   a_entry_clear: assert property (exc_entry |-> (machine_state_o & 32'h0000_EF02) == '0)
      else $error("state bits not cleared on entry");
   a_entry_keep: assert property (exc_entry |-> $stable(machine_state_o[MST_MC])
      && $stable(machine_state_o[MST_VB])) else $error("machine check or base bit altered");
   a_byte_order: assert property (exc_entry |->
      machine_state_o[MST_BO] == $past(machine_state_o[MST_HBO]))
      else $error("byte order not taken from handler byte order");
   // a reset request abandons the sequence, so it disables this check
   a_entry_latency: assert property (disable iff (rst_i || core_reset_req_i)
      exc_entry |-> !issue_en_o [*2] ##[1:4] issue_en_o) else $error("handler issue timing");
   a_issue_drop: assert property (issue_en_o && handler_issued_i && !core_reset_req_i |=>
      !issue_en_o) else $error("issue enable held after handler issued");
   a_reset_state: assert property (rst_fetch |-> (machine_state_o & ~32'h0000_1040) == '0)
      else $error("reset state bits not cleared");
   a_reset_vector: assert property (rst_fetch |-> fetch_addr_o[19:0] == 20'h0_0100
      && issue_en_o) else $error("reset vector offset wrong");
   a_rfi_refetch: assert property (kill_o && retire_o |-> fetch_req_o)
      else $error("return did not refetch");
   // main scenarios
   c_entry: cover property (exc_entry);
   c_rfi: cover property (kill_o && retire_o);
   c_reset: cover property (rst_fetch);
endmodule
bind exc_sequencer exc_props #(.RESTORE_CYCLES(RESTORE_CYCLES)) u_props (.clk_i(clk_i),
   .rst_i(rst_i), .core_reset_req_i(core_reset_req_i), .handler_issued_i(handler_issued_i),
   .retire_o(retire_o), .kill_o(kill_o), .fetch_req_o(fetch_req_o),
   .fetch_addr_o(fetch_addr_o), .issue_en_o(issue_en_o), .machine_state_o(machine_state_o));

// *** dv/pipe_model.sv ***
`timescale 1ns/1ps
module pipe_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // issue side
   input wire logic issue_en_i,
   input wire logic slow_i,
   output logic issued_o
);
   // ------------------------------------------------------------
   // handler issue after a memory dependent fetch time
   // ------------------------------------------------------------
   int cnt_r; // cycles waited since issue was allowed
   // never issues sooner than two clocks, slow mode models a slow memory
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !issue_en_i || issued_o)
      begin
         cnt_r <= 0;
         issued_o <= 1'b0;
      end
      else if (cnt_r >= (slow_i ? 6 : 2))
         issued_o <= 1'b1;
      else
         cnt_r <= cnt_r + 1;
   end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
   import exc_pkg::*;
   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic rreq = 1'b0, cfg = 1'b0, slow = 1'b0, berr = 1'b0, bhit = 1'b0;
   logic hv = 1'b0, hc = 1'b0, hx = 1'b0, hr = 1'b0;
   exc_t ht = EXC_OTHER;
   logic [31:0] pc = '0, voff = '0, dea = '0, iinfo = '0, bea = '0, kea = '0;
   logic [15:0] xinfo = '0;
   logic wcyc = 1'b0, wstb = 1'b0, wwe = 1'b0;
   logic [6:0] wadr = '0;
   logic [31:0] wdat = '0;
   logic retire, kill, freq, issue, issued, ack;
   logic [31:0] faddr, mst, rdat, q;
   int miscompares = 0, n_compared = 0, cycles = 0;
   always #10 clk_i = ~clk_i;
   exc_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .core_reset_req_i(rreq),
      .cfg_vector_high_i(cfg), .head_valid_i(hv), .head_complete_i(hc), .head_exc_i(hx),
      .head_exc_type_i(ht), .head_is_rfi_i(hr), .head_pc_i(pc), .head_vec_off_i(voff),
      .head_exc_info_i(xinfo), .head_data_ea_i(dea), .head_instr_info_i(iinfo),
      .bus_err_i(berr), .bus_err_ea_i(bea), .bkpt_hit_i(bhit), .bkpt_ea_i(kea),
      .handler_issued_i(issued), .retire_o(retire), .kill_o(kill), .fetch_req_o(freq),
      .fetch_addr_o(faddr), .issue_en_o(issue), .machine_state_o(mst), .wb_cyc_i(wcyc),
      .wb_stb_i(wstb), .wb_we_i(wwe), .wb_adr_i(wadr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack));
   pipe_model u_model (.clk_i(clk_i), .rst_i(rst_i), .issue_en_i(issue), .slow_i(slow),
      .issued_o(issued));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task results();
      if (miscompares == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   // classic cycle: request held until ack is sampled, then released
   task wb(input logic we, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {wcyc, wstb, wwe, wadr, wdat} <= {2'b11, we, a, d};
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      q = rdat;
      {wcyc, wstb} <= 2'b00;
   endtask
   task rd(input string n, input logic [6:0] a, input logic [31:0] e);
      wb(1'b0, a, '0);
      chk(n, e, q);
   endtask
   // one head event, taken at the second edge, outputs seen after it
   task head(input logic c, input logic x, input exc_t t, input logic r);
      @(posedge clk_i);
      {hv, hc, hx, hr} <= {1'b1, c, x, r};
      ht <= t;
      @(posedge clk_i);
      {hv, hc, hx, hr} <= 4'h0;
      #1;
   endtask
   // one cycle bus error or breakpoint event from the load/store side
   task pulse(input logic k, input logic [31:0] a);
      @(posedge clk_i);
      {berr, bhit, bea, kea} <= {!k, k, a, a};
      @(posedge clk_i);
      {berr, bhit} <= 2'b00;
   endtask
   // bounded wait for the handler issue window to open and close
   task wait_handler();
      repeat (30) if (issue !== 1'b1) @(posedge clk_i);
      chk("issue_en", 1, issue);
      repeat (30) if (issue === 1'b1) @(posedge clk_i);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs();
      rd("mst", OFF_MST, '0);
      wb(1'b1, 7'h7C, 32'hFFFF_FFFF);
      rd("unmapped", 7'h7C, '0);
      head(1'b0, 1'b0, EXC_OTHER, 1'b0);
      chk("retire_incomplete", 0, retire);
      head(1'b1, 1'b0, EXC_OTHER, 1'b0);
      chk("retire", 1, retire);
      chk("kill_retire", 0, kill);
   endtask
   task t_align();
      wb(1'b1, OFF_MST, 32'h0001_D000);
      {pc, voff, dea, iinfo, xinfo} <= {32'h0000_2000, 32'h0000_0600, 32'h1234_5678,
         32'h0000_4321, 16'h0042};
      head(1'b1, 1'b1, EXC_ALIGN, 1'b0);
      chk("kill", 1, kill);
      chk("fetch_addr", 32'h0000_0600, faddr);
      chk("mst_entry", 32'h0001_1001, mst);
      wait_handler();
      rd("svpc", OFF_SVPC, 32'h0000_2000);
      rd("svst", OFF_SVST, 32'h0042_D000);
      rd("fad", OFF_FAD, 32'h1234_5678);
      rd("fcaus", OFF_FCAUS, 32'h0000_4321);
   endtask
   task t_mchk();
      wb(1'b1, OFF_MST, 32'h0000_0040);
      slow <= 1'b1;
      pulse(1'b0, 32'hA000_0010);
      pulse(1'b0, 32'hA000_0020);
      {voff, iinfo} <= {32'h0000_0200, 32'h0000_0777};
      head(1'b1, 1'b1, EXC_MCHK, 1'b0);
      chk("fetch_high", 32'hFFF0_0200, faddr);
      wait_handler();
      rd("fad_first", OFF_FAD, 32'hA000_0010);
      rd("fcaus_mchk", OFF_FCAUS, 32'h0000_0777);
   endtask
   task t_bkpt();
      pulse(1'b1, 32'hB000_0004);
      pulse(1'b1, 32'hB000_0008);
      head(1'b1, 1'b1, EXC_BKPT, 1'b0);
      wait_handler();
      rd("bar", OFF_BAR, 32'hB000_0004);
      rd("fad_keep", OFF_FAD, 32'hA000_0010);
      iinfo <= 32'h0000_0999;
      head(1'b1, 1'b1, EXC_OTHER, 1'b0);
      wait_handler();
      rd("fcaus_keep", OFF_FCAUS, 32'h0000_0777);
   endtask
   task t_rfi();
      wb(1'b1, OFF_MST, '0);
      wb(1'b1, OFF_SVPC, 32'h0000_3000);
      wb(1'b1, OFF_SVST, 32'h0000_C001);
      head(1'b1, 1'b0, EXC_OTHER, 1'b1);
      chk("rfi_retire", 1, retire & kill);
      chk("rfi_fetch", 32'h0000_3000, faddr);
      rd("mst_rfi", OFF_MST, 32'h0000_C001);
   endtask
   // reset request lands in mid-sequence and must win
   task t_reset();
      wb(1'b1, OFF_FAD, 32'h5555_AAAA);
      wb(1'b1, OFF_CNTA, 32'hABCD_1234);
      wb(1'b1, OFF_FEXC, 32'hFFFF_FFFF);
      wb(1'b1, OFF_DMM, '0);
      wb(1'b1, OFF_MST, 32'h0000_9000);
      {cfg, slow, voff} <= {2'b10, 32'h0000_0700};
      head(1'b1, 1'b1, EXC_OTHER, 1'b0);
      @(posedge clk_i) rreq <= 1'b1;
      repeat (4) @(posedge clk_i);
      rreq <= 1'b0;
      repeat (30) if (freq !== 1'b1) @(posedge clk_i) #1;
      chk("reset_vector", 32'hFFF0_0100, faddr);
      chk("mst_reset", 32'h0000_1040, mst);
      wait_handler();
      rd("fad_reset", OFF_FAD, 32'h5555_AAAA);
      rd("cnta_reset", OFF_CNTA, 32'hABCD_0000);
      rd("fexc_reset", OFF_FEXC, '0);
      rd("dmm_reset", OFF_DMM, 32'h2800_000F);
   endtask
   // ------------------------------------------------------------
   // sequence and hang guard
   // ------------------------------------------------------------
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_align();
      t_mchk();
      t_bkpt();
      t_rfi();
      t_reset();
      results();
   end
endmodule
